// File: common/ces_pkg.sv
// Shared constants and types for the evaluation stack register set
package ces_pkg;
  // Shared internal bus, float and nibble widths and priority count
  localparam int CES_WORD_W = 32;
  localparam int CES_FLOAT_W = 32;
  localparam int CES_NIB_W = 4;
  localparam int CES_NUM_PRI = 2;
  // Reset values
  localparam logic [31:0] CES_RST_WORD = 32'h00000000;
  localparam logic [31:0] CES_RST_IPTR = 32'h00000000;
  localparam logic [31:0] CES_RST_WPTR = 32'h00000000;
  // Field positions and steps
  localparam int CES_PFX_SHIFT = 4;
  localparam int CES_WORD_SHIFT = 2;
  localparam logic [31:0] CES_IPTR_STEP = 32'h00000001;
  // Priority switch timing
  localparam int CES_CLK_NS = 50;
  localparam int CES_RESP_NS = 3000;
  localparam int CES_RESP_CYC = (CES_RESP_NS / CES_CLK_NS) < 1 ? 1 :
                                (CES_RESP_NS / CES_CLK_NS);
  localparam int CES_RESP_CNT_W = 8;

  typedef enum logic [3:0] {
    CES_OP_NONE,
    CES_OP_PFIX,
    CES_OP_NFIX,
    CES_OP_LDC,
    CES_OP_LDMEM,
    CES_OP_STMEM,
    CES_OP_ADD,
    CES_OP_SETWP,
    CES_OP_LDWP,
    CES_OP_JUMP,
    CES_OP_FLD,
    CES_OP_FST
  } ces_op_t;

  typedef enum logic [1:0] {
    CES_SK_HOLD,
    CES_SK_PUSH,
    CES_SK_POP,
    CES_SK_POPSET
  } ces_sk_t;

  typedef enum logic {
    CES_PRI_LOW,
    CES_PRI_HIGH
  } ces_pri_t;
endpackage

// File: rtl/ces_stack3.sv
// Three-entry push/pop register stack
`timescale 1ns/1ps
module ces_stack3 #(
  parameter int W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Stack command
  input wire ces_pkg::ces_sk_t sk_op,
  input wire logic [W-1:0] sk_din,
  // Stack contents
  output logic [W-1:0] top,
  output logic [W-1:0] second,
  output logic [W-1:0] third
);
  import ces_pkg::*;

  logic [W-1:0] top_ff;
  logic [W-1:0] second_ff;
  logic [W-1:0] third_ff;
  logic [W-1:0] nxt_top;
  logic [W-1:0] nxt_second;
  logic [W-1:0] nxt_third;

  always_comb begin
    nxt_top = top_ff;
    nxt_second = second_ff;
    nxt_third = third_ff;
    case (sk_op)
      CES_SK_PUSH: begin
        // Old third falls off; no overflow check, code must avoid it
        nxt_third = second_ff; // [RULE1] [RULE3] [RULE5]
        nxt_second = top_ff; // [RULE1]
        nxt_top = sk_din; // [RULE1]
      end
      CES_SK_POP: begin
        // Third keeps its stale value
        nxt_top = second_ff; // [RULE2] [RULE3]
        nxt_second = third_ff; // [RULE2]
      end
      CES_SK_POPSET: begin
        // Two operands consumed, result lands on top
        nxt_top = sk_din; // [RULE4]
        nxt_second = third_ff; // [RULE4]
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      top_ff <= '0;
      second_ff <= '0;
      third_ff <= '0;
    end else begin
      top_ff <= nxt_top;
      second_ff <= nxt_second;
      third_ff <= nxt_third;
    end
  end

  assign top = top_ff;
  assign second = second_ff;
  assign third = third_ff;
endmodule

// File: rtl/ces_regs.sv
// Sequential-process registers with integer and banked float stacks
// Operation
// [RULE1] A load pushes second into third, top into second, then new top.
// [RULE2] A store from top pops second into top and third into second.
// [RULE3] A push drops the old third; a pop leaves third stale.
// [RULE4] Add sums top and second and leaves the result on top.
// [RULE5] No overflow detection; a fourth load loses the deepest entry.
// [RULE6] The float stack has three entries pushing and popping likewise.
// [RULE7] Float load/store addresses come from the integer stack top.
// [RULE8] The float stack is duplicated per priority level.
// [RULE9] Two priority levels, with runnable high work always preferred.
// [RULE10] A low to high switch completes within about 3 us.
// [RULE11] Process state is six registers: wptr, iptr, oreg and A, B, C.
// [RULE12] The workspace pointer holds the local variable area address.
// [RULE13] The instruction pointer holds the next instruction address.
// [RULE14] The operand register builds each instruction's operand.
// [RULE15] Data words are 32 bits wide, as on the shared internal bus.
// [RULE16] Every non-prefix instruction clears the operand register.
`timescale 1ns/1ps
module ces_regs #(
  parameter int FW = ces_pkg::CES_FLOAT_W,
  parameter int RESP_CYC = ces_pkg::CES_RESP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction from decode
  input wire logic op_valid,
  input wire ces_pkg::ces_op_t op_code,
  input wire logic [ces_pkg::CES_NIB_W-1:0] op_nib,
  output logic op_ready,
  // Read data from the internal bus
  input wire logic [ces_pkg::CES_WORD_W-1:0] bus_rdata,
  input wire logic [FW-1:0] fload_data,
  // Scheduler
  input wire logic hi_runnable,
  output ces_pkg::ces_pri_t cur_pri,
  output logic pri_switched,
  // Store results
  output logic st_valid,
  output logic [ces_pkg::CES_WORD_W-1:0] st_addr,
  output logic [ces_pkg::CES_WORD_W-1:0] st_data,
  output logic fst_valid,
  output logic [FW-1:0] fst_data,
  // Process registers
  output logic [ces_pkg::CES_WORD_W-1:0] wptr,
  output logic [ces_pkg::CES_WORD_W-1:0] iptr,
  output logic [ces_pkg::CES_WORD_W-1:0] oreg,
  output logic [ces_pkg::CES_WORD_W-1:0] eval_top,
  output logic [ces_pkg::CES_WORD_W-1:0] eval_second,
  output logic [ces_pkg::CES_WORD_W-1:0] eval_third,
  output logic [FW-1:0] float_top,
  output logic [FW-1:0] float_second,
  output logic [FW-1:0] float_third
);
  import ces_pkg::*;

  localparam int W = CES_WORD_W;

  // Process state
  logic [W-1:0] wptr_ff;
  logic [W-1:0] iptr_ff;
  logic [W-1:0] oreg_ff;
  logic [W-1:0] nxt_wptr;
  logic [W-1:0] nxt_iptr;
  logic [W-1:0] nxt_oreg;

  // Store result registers
  logic st_valid_ff;
  logic [W-1:0] st_addr_ff;
  logic [W-1:0] st_data_ff;
  logic fst_valid_ff;
  logic [FW-1:0] fst_data_ff;
  logic nxt_st_valid;
  logic [W-1:0] nxt_st_addr;
  logic [W-1:0] nxt_st_data;
  logic nxt_fst_valid;
  logic [FW-1:0] nxt_fst_data;

  // Priority state
  ces_pri_t pri_ff;
  ces_pri_t nxt_pri;
  logic pfx_open_ff;
  logic nxt_pfx_open;
  logic [CES_RESP_CNT_W-1:0] wait_ff;
  logic [CES_RESP_CNT_W-1:0] nxt_wait;
  logic sw_ff;
  logic nxt_sw;

  // Stack controls
  ces_sk_t int_sk;
  logic [W-1:0] int_din;
  ces_sk_t flt_sk;
  logic [FW-1:0] flt_din;
  logic [W-1:0] a_q;
  logic [W-1:0] b_q;
  logic [W-1:0] c_q;
  logic [FW-1:0] fa_q [CES_NUM_PRI];
  logic [FW-1:0] fb_q [CES_NUM_PRI];
  logic [FW-1:0] fc_q [CES_NUM_PRI];

  logic [W-1:0] operand;
  logic want_sw;
  ces_pri_t want_pri;
  logic do_sw;
  logic op_take;

  // Word offset from operand, used by local stores and workspace address loads
  function automatic logic [W-1:0] word_off(input logic [W-1:0] base,
                                            input logic [W-1:0] idx);
    word_off = base + (idx << CES_WORD_SHIFT);
  endfunction

  // Integer stack: A, B and C
  ces_stack3 #(
    .W(W)
  ) u_int_stack (
    .clk(clk),
    .rst(rst),
    .sk_op(int_sk),
    .sk_din(int_din),
    .top(a_q),
    .second(b_q),
    .third(c_q)
  );

  // One float stack per priority so a switch saves nothing
  genvar gp;
  generate
    for (gp = 0; gp < CES_NUM_PRI; gp++) begin : g_fbank
      ces_sk_t bank_sk;
      always_comb begin
        bank_sk = (int'(pri_ff) == gp) ? flt_sk : CES_SK_HOLD; // [RULE8]
      end
      ces_stack3 #(
        .W(FW)
      ) u_flt_stack (
        .clk(clk),
        .rst(rst),
        .sk_op(bank_sk),
        .sk_din(flt_din),
        .top(fa_q[gp]),
        .second(fb_q[gp]),
        .third(fc_q[gp])
      );
    end
  endgenerate

  // Priority switch: wait for an instruction boundary, but force it
  // once the response budget runs out; a forced switch drops any
  // half-built prefix operand.
  // The 8-bit wait counter limits RESP_CYC to 256
  always_comb begin
    // High work is preferred whenever it is runnable
    want_pri = hi_runnable ? CES_PRI_HIGH : CES_PRI_LOW; // [RULE9]
    want_sw = want_pri != pri_ff; // [RULE9]
    do_sw = want_sw &&
            (!pfx_open_ff ||
             wait_ff >= CES_RESP_CNT_W'(RESP_CYC - 1)); // [RULE10]
    nxt_pri = do_sw ? want_pri : pri_ff;
    nxt_sw = do_sw;
    if (want_sw && !do_sw) begin
      nxt_wait = wait_ff + CES_RESP_CNT_W'(1); // [RULE10]
    end else begin
      nxt_wait = '0;
    end
  end

  // Switch cycle holds off decode so no instruction straddles it
  assign op_ready = !do_sw;
  assign op_take = op_valid && op_ready;

  // Instruction execution
  always_comb begin
    operand = oreg_ff | {{(W - CES_NIB_W){1'b0}}, op_nib}; // [RULE14]
    nxt_wptr = wptr_ff;
    nxt_iptr = iptr_ff;
    nxt_oreg = oreg_ff;
    nxt_pfx_open = pfx_open_ff;
    nxt_st_valid = 1'b0;
    nxt_st_addr = st_addr_ff;
    nxt_st_data = st_data_ff;
    nxt_fst_valid = 1'b0;
    nxt_fst_data = fst_data_ff;
    int_sk = CES_SK_HOLD;
    int_din = '0;
    flt_sk = CES_SK_HOLD;
    flt_din = '0;
    if (do_sw) begin
      nxt_oreg = '0;
      nxt_pfx_open = 1'b0;
    end else if (op_take) begin
      nxt_iptr = iptr_ff + CES_IPTR_STEP; // [RULE13]
      nxt_oreg = '0; // [RULE16]
      nxt_pfx_open = 1'b0;
      case (op_code)
        CES_OP_PFIX: begin
          nxt_oreg = operand << CES_PFX_SHIFT; // [RULE14]
          nxt_pfx_open = 1'b1;
        end
        CES_OP_NFIX: begin
          nxt_oreg = (~operand) << CES_PFX_SHIFT; // [RULE14]
          nxt_pfx_open = 1'b1;
        end
        CES_OP_LDC: begin
          int_sk = CES_SK_PUSH; // [RULE1]
          int_din = operand;
        end
        CES_OP_LDMEM: begin
          int_sk = CES_SK_PUSH; // [RULE1] [RULE15]
          int_din = bus_rdata;
        end
        CES_OP_STMEM: begin
          int_sk = CES_SK_POP; // [RULE2]
          nxt_st_valid = 1'b1;
          nxt_st_data = a_q;
          nxt_st_addr = word_off(wptr_ff, operand); // [RULE12]
        end
        CES_OP_ADD: begin
          int_sk = CES_SK_POPSET; // [RULE4]
          int_din = a_q + b_q; // [RULE4]
        end
        CES_OP_SETWP: begin
          nxt_wptr = a_q; // [RULE12]
          int_sk = CES_SK_POP; // [RULE2]
        end
        CES_OP_LDWP: begin
          int_sk = CES_SK_PUSH; // [RULE1]
          int_din = word_off(wptr_ff, operand); // [RULE12]
        end
        CES_OP_JUMP: begin
          nxt_iptr = iptr_ff + CES_IPTR_STEP + operand; // [RULE13]
        end
        CES_OP_FLD: begin
          // Address was on A; the fetched value goes to the float stack
          int_sk = CES_SK_POP; // [RULE7]
          flt_sk = CES_SK_PUSH; // [RULE6]
          flt_din = fload_data;
        end
        CES_OP_FST: begin
          int_sk = CES_SK_POP; // [RULE7]
          flt_sk = CES_SK_POP; // [RULE6]
          nxt_st_addr = a_q; // [RULE7]
          nxt_fst_valid = 1'b1;
          nxt_fst_data = fa_q[pri_ff];
        end
        CES_OP_NONE: begin
          // Idle slot: only steps iptr and clears oreg
          nxt_oreg = '0; // [RULE16]
        end
        default: begin
        end
      endcase
    end
  end

  // Only six process registers; stacks live in the submodules
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr_ff <= CES_RST_WPTR; // [RULE11]
      iptr_ff <= CES_RST_IPTR;
      oreg_ff <= CES_RST_WORD;
      pfx_open_ff <= 1'b0;
      pri_ff <= CES_PRI_LOW;
      wait_ff <= '0;
      sw_ff <= 1'b0;
      st_valid_ff <= 1'b0;
      st_addr_ff <= CES_RST_WORD;
      st_data_ff <= CES_RST_WORD;
      fst_valid_ff <= 1'b0;
      fst_data_ff <= '0;
    end else begin
      wptr_ff <= nxt_wptr;
      iptr_ff <= nxt_iptr;
      oreg_ff <= nxt_oreg;
      pfx_open_ff <= nxt_pfx_open;
      pri_ff <= nxt_pri;
      wait_ff <= nxt_wait;
      sw_ff <= nxt_sw;
      st_valid_ff <= nxt_st_valid;
      st_addr_ff <= nxt_st_addr;
      st_data_ff <= nxt_st_data;
      fst_valid_ff <= nxt_fst_valid;
      fst_data_ff <= nxt_fst_data;
    end
  end

  assign wptr = wptr_ff;
  assign iptr = iptr_ff;
  assign oreg = oreg_ff;
  assign eval_top = a_q;
  assign eval_second = b_q;
  assign eval_third = c_q;
  assign float_top = fa_q[pri_ff];
  assign float_second = fb_q[pri_ff];
  assign float_third = fc_q[pri_ff];
  assign cur_pri = pri_ff;
  assign pri_switched = sw_ff;
  assign st_valid = st_valid_ff;
  assign st_addr = st_addr_ff;
  assign st_data = st_data_ff;
  assign fst_valid = fst_valid_ff;
  assign fst_data = fst_data_ff;
endmodule

// File: tb/ces_regs_props.sv
// Checker for the evaluation stack register set
`timescale 1ns/1ps
module ces_regs_props #(
  parameter int FW = 32,
  parameter int RESP_CYC = 60
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Instruction
  input wire logic op_valid,
  input wire ces_pkg::ces_op_t op_code,
  input wire logic [ces_pkg::CES_NIB_W-1:0] op_nib,
  input wire logic op_ready,
  input wire logic [FW-1:0] fload_data,
  // Scheduler
  input wire logic hi_runnable,
  input wire ces_pkg::ces_pri_t cur_pri,
  input wire logic pri_switched,
  // Results
  input wire logic st_valid,
  input wire logic [31:0] st_addr,
  input wire logic [31:0] st_data,
  input wire logic fst_valid,
  input wire logic [FW-1:0] fst_data,
  // Registers
  input wire logic [31:0] iptr,
  input wire logic [31:0] oreg,
  input wire logic [31:0] eval_top,
  input wire logic [31:0] eval_second,
  input wire logic [31:0] eval_third,
  input wire logic [FW-1:0] float_top,
  input wire logic [FW-1:0] float_second,
  input wire logic [FW-1:0] float_third
);
  import ces_pkg::*;
  logic taken;
  logic [31:0] opnd;
  logic [7:0] wait_ff;
  logic [7:0] nxt_wait;
  assign taken = op_valid && op_ready;
  assign opnd = oreg | {28'h0000000, op_nib};
  // Counts cycles spent low while high work waits
  always_comb begin
    nxt_wait = 8'h00;
    if (hi_runnable && cur_pri == CES_PRI_LOW) begin
      nxt_wait = wait_ff + 8'h01;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_ff <= 8'h00;
    end else begin
      wait_ff <= nxt_wait;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_PUSH: assert property (
    taken && op_code == CES_OP_LDC |=> eval_top == $past(opnd) &&
    eval_second == $past(eval_top) && eval_third == $past(eval_second))
    else $error("push did not shift the stack");
  AST_POP: assert property (
    taken && op_code == CES_OP_STMEM |=> st_valid &&
    st_data == $past(eval_top) && eval_top == $past(eval_second) &&
    eval_second == $past(eval_third) && eval_third == $past(eval_third))
    else $error("store did not pop the stack");
  AST_ADD: assert property (
    taken && op_code == CES_OP_ADD |=> eval_second == $past(eval_third)
    && eval_top == $past(eval_top) + $past(eval_second))
    else $error("add result wrong");
  AST_FLOAD: assert property (
    taken && op_code == CES_OP_FLD |=> float_top == $past(fload_data) &&
    float_second == $past(float_top) && float_third == $past(float_second)
    && eval_top == $past(eval_second))
    else $error("float load wrong");
  AST_FSTORE: assert property (
    taken && op_code == CES_OP_FST |=> fst_valid && st_addr ==
    $past(eval_top) && fst_data == $past(float_top) &&
    float_top == $past(float_second))
    else $error("float store wrong");
  AST_PREFIX: assert property (
    taken && op_code == CES_OP_PFIX |=> oreg == ($past(opnd) << 4))
    else $error("prefix did not build operand");
  AST_OREG_CLR: assert property (
    taken && !(op_code inside {CES_OP_PFIX, CES_OP_NFIX}) |=>
    oreg == 32'h00000000)
    else $error("operand not cleared");
  AST_IPTR: assert property (
    taken && op_code != CES_OP_JUMP |=> iptr == $past(iptr) + 32'h00000001)
    else $error("instruction pointer step wrong");
  AST_SWITCH: assert property (
    !op_ready |=> cur_pri != $past(cur_pri) && pri_switched)
    else $error("priority switch sequence wrong");
  AST_RESP: assert property (
    wait_ff <= RESP_CYC)
    else $error("high priority waited too long");
endmodule

bind ces_regs ces_regs_props #(.FW(FW), .RESP_CYC(RESP_CYC)) i_ces_regs_props (
  .clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
  .op_nib(op_nib), .op_ready(op_ready), .fload_data(fload_data),
  .hi_runnable(hi_runnable), .cur_pri(cur_pri), .pri_switched(pri_switched),
  .st_valid(st_valid), .st_addr(st_addr), .st_data(st_data),
  .fst_valid(fst_valid), .fst_data(fst_data), .iptr(iptr), .oreg(oreg),
  .eval_top(eval_top), .eval_second(eval_second), .eval_third(eval_third),
  .float_top(float_top), .float_second(float_second),
  .float_third(float_third));

// File: tb/test_ces_regs.sv
// Self-checking testbench for the evaluation stack register set
`timescale 1ns/1ps
module test_ces_regs;
  import ces_pkg::*;
  // Short response bound keeps the switch tests brief
  localparam int RESP = 4;
  localparam logic [31:0] Z = 32'h00000000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic op_valid = 1'b0;
  ces_op_t op_code = CES_OP_NONE;
  logic [3:0] op_nib = 4'h0;
  logic [31:0] bus_rdata = 32'h00000000;
  logic [31:0] fload_data = 32'h00000000;
  logic hi_runnable = 1'b0;
  logic op_ready, pri_switched, st_valid, fst_valid;
  ces_pri_t cur_pri;
  logic [31:0] st_addr, st_data, fst_data, wptr, iptr, oreg;
  logic [31:0] eval_top, eval_second, eval_third;
  logic [31:0] float_top, float_second, float_third;
  logic [31:0] exp_ip = 32'h00000000;
  int n_fail = 0;
  int n_compared = 0;

  ces_regs #(.FW(32), .RESP_CYC(RESP)) i_ces_regs (
    .clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
    .op_nib(op_nib), .op_ready(op_ready), .bus_rdata(bus_rdata),
    .fload_data(fload_data), .hi_runnable(hi_runnable), .cur_pri(cur_pri),
    .pri_switched(pri_switched), .st_valid(st_valid), .st_addr(st_addr),
    .st_data(st_data), .fst_valid(fst_valid), .fst_data(fst_data),
    .wptr(wptr), .iptr(iptr), .oreg(oreg), .eval_top(eval_top),
    .eval_second(eval_second), .eval_third(eval_third),
    .float_top(float_top), .float_second(float_second),
    .float_third(float_third));

  always #25 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // Holds the op until ready, so a switch cycle never drops it
  task automatic do_op(input ces_op_t code, input logic [3:0] nib,
                       input logic [31:0] fdat);
    @(negedge clk);
    op_valid = 1'b1;
    op_code = code;
    op_nib = nib;
    fload_data = fdat;
    bus_rdata = fdat;
    #1;
    while (op_ready !== 1'b1) begin
      @(negedge clk);
      #1;
    end
    @(posedge clk);
    #1;
    exp_ip = exp_ip + 32'h00000001;
  endtask

  task automatic wait_pri(input ces_pri_t p, input int lim);
    int n;
    n = 0;
    while (cur_pri !== p && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({31'h00000000, cur_pri}, {31'h00000000, p}, "priority");
    chk({31'h00000000, pri_switched}, 32'h00000001, "switch");
  endtask

  task automatic t_stack();
    chk(eval_top | eval_second | eval_third | oreg, Z, "reset");
    do_op(CES_OP_LDC, 4'h1, Z);
    do_op(CES_OP_LDC, 4'h2, Z);
    do_op(CES_OP_LDC, 4'h3, Z);
    do_op(CES_OP_LDC, 4'h4, Z);
    chk(eval_second, 32'h00000003, "second");
    chk(eval_third, 32'h00000002, "third");
    do_op(CES_OP_STMEM, 4'h2, Z);
    chk(st_data, 32'h00000004, "st_data");
    chk(st_addr, 32'h00000008, "st_addr");
    chk({31'h00000000, st_valid}, 32'h00000001, "st_valid");
    chk(eval_third, 32'h00000002, "stale third");
    do_op(CES_OP_ADD, 4'h0, Z);
    chk(eval_top, 32'h00000005, "sum");
    do_op(CES_OP_LDMEM, 4'h0, 32'h89ABCDEF);
    chk(eval_top, 32'h89ABCDEF, "bus load");
    chk(iptr, exp_ip, "iptr");
    $display("test stack done");
  endtask

  task automatic t_operand();
    do_op(CES_OP_PFIX, 4'h1, Z);
    chk(oreg, 32'h00000010, "prefix");
    do_op(CES_OP_LDC, 4'h2, Z);
    chk(eval_top, 32'h00000012, "long const");
    chk(oreg, Z, "cleared");
    do_op(CES_OP_PFIX, 4'h5, Z);
    do_op(CES_OP_NONE, 4'h0, Z);
    chk(oreg, Z, "idle clears");
    do_op(CES_OP_NFIX, 4'h0, Z);
    do_op(CES_OP_LDC, 4'h3, Z);
    chk(eval_top, 32'hFFFFFFF3, "negative");
    do_op(CES_OP_LDC, 4'hC, Z);
    do_op(CES_OP_SETWP, 4'h0, Z);
    chk(wptr, 32'h0000000C, "wptr");
    do_op(CES_OP_LDWP, 4'h1, Z);
    chk(eval_top, 32'h00000010, "local addr");
    do_op(CES_OP_JUMP, 4'h3, Z);
    exp_ip = exp_ip + 32'h00000003;
    chk(iptr, exp_ip, "jump");
    $display("test operand done");
  endtask

  task automatic t_float();
    do_op(CES_OP_LDC, 4'h7, Z);
    do_op(CES_OP_FLD, 4'h0, 32'h11111111);
    do_op(CES_OP_LDC, 4'h7, Z);
    do_op(CES_OP_FLD, 4'h0, 32'hA5A5A5A5);
    chk(float_second, 32'h11111111, "float push");
    do_op(CES_OP_LDC, 4'h9, Z);
    do_op(CES_OP_FST, 4'h0, Z);
    chk(fst_data, 32'hA5A5A5A5, "fst_data");
    chk({31'h00000000, fst_valid}, 32'h00000001, "fst_valid");
    chk(st_addr, 32'h00000009, "float addr");
    chk(float_top, 32'h11111111, "float pop");
    $display("test float done");
  endtask

  task automatic t_bank();
    do_op(CES_OP_PFIX, 4'h1, Z);
    @(negedge clk);
    op_valid = 1'b0;
    hi_runnable = 1'b1;
    wait_pri(CES_PRI_HIGH, RESP + 2);
    chk(float_top, Z, "high bank");
    do_op(CES_OP_LDC, 4'h1, Z);
    do_op(CES_OP_FLD, 4'h0, 32'h44444444);
    @(negedge clk);
    op_valid = 1'b0;
    hi_runnable = 1'b0;
    wait_pri(CES_PRI_LOW, RESP + 2);
    chk(float_top, 32'h11111111, "low bank kept");
    $display("test bank done");
  endtask

  task automatic complete_run();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Whole run is about 34 cycles; the timeout allows 3000
  initial begin
    #(3000 * 50);
    n_fail++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_stack();
    t_operand();
    t_float();
    t_bank();
    complete_run();
  end
endmodule
